// File: logic/livs_top.v
/*
 * lin interrupt vector and status flags: latches lin event strobes,
 * priority encodes them into a 4-bit vector, keeps the state flags,
 * the queue threshold fields, the monitor bit and the bus idle timer.
 * assumes: event strobes and fifo levels come from logic on i_sys_clk;
 * the bus level pin is asynchronous and is synchronised here.
 */
// Decided for this implementation: the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
`include "livs_map.vh"

// Operation
// - wake-up in sleep sets vector 0
// - sleep activity sets 1 if monitor set
// - valid or sent identifier sets vector 2
// - byte into full receive fifo sets 3
// - other communication error sets vector 4
// - codes 5,7,9,14 never produced
// - rx level above threshold sets 6
// - last byte, good checksum sets 8
// - tx level below threshold sets 10
// - last byte sent without error sets 11
// - no master response sets 12
// - bus idle over four seconds sets 13
// - nothing pending shows code 15
// - state register: pending bit1, busy bit0
// - vector shows highest priority pending code
// - reset returns vector to 0fh
// - pending flag set on any condition
// - busy flag while state machine communicates
module livs_top
(
    // clock and reset
    input  wire                    i_sys_clk,
    input  wire                    i_srst,
    // register port
    input  wire [`LIVS_ADDR_W-1:0] i_reg_addr,
    input  wire [7:0]              i_reg_wdata,
    input  wire                    i_reg_wr,
    input  wire                    i_reg_rd,
    output reg  [7:0]              o_reg_rdata,
    // lin mode and protocol state
    input  wire                    i_lin_mode,
    input  wire                    i_lin_master,
    input  wire                    i_sleep,
    input  wire                    i_sm_active,
    input  wire                    i_bus_pin,
    // event strobes
    input  wire                    i_wake_det,
    input  wire                    i_bus_act,
    input  wire                    i_id_ok_rx,
    input  wire                    i_id_sent,
    input  wire                    i_rx_byte,
    input  wire                    i_comm_err,
    input  wire                    i_rx_last,
    input  wire                    i_cksum_ok,
    input  wire                    i_tx_last,
    input  wire                    i_tx_err,
    input  wire                    i_no_resp,
    // fifo fill levels
    input  wire [`LIVS_LVL_W-1:0]  i_rx_level,
    input  wire [`LIVS_LVL_W-1:0]  i_tx_level,
    // service strobes, one per source, from the consumer of each event
    input  wire [`LIVS_NSRC-1:0]   i_svc_clr,
    // interrupt vector and flags
    output reg  [`LIVS_VEC_W-1:0]  o_vector,
    output reg                     o_irq_pending,
    output reg                     o_busy
);

////////////////////////////////////////////////////////////////////////////
// software registers
// register map on the byte port:
//   0f  vector, bits 7:4 read zero, read only
//   11  state flags, bit 1 pending, bit 0 busy, read only
//   13  queue control, 5:4 tx threshold, 3:2 rx threshold
//   15  second control, bit 3 activity monitor
//   any other index reads zero and drops writes

reg  [7:0]              qctrl_q;
reg  [7:0]              ctrl2_q;
wire [1:0]              rx_fill_threshold = qctrl_q[`LIVS_QC_RX_FILL_THRESHOLD_HI:`LIVS_QC_RX_FILL_THRESHOLD_LO];
wire [1:0]              tx_fill_threshold = qctrl_q[`LIVS_QC_TX_FILL_THRESHOLD_HI:`LIVS_QC_TX_FILL_THRESHOLD_LO];
wire                    mon_en = ctrl2_q[`LIVS_CTRL2_MON_BIT];

// writes to the two control registers; others are read only
// a write to a read-only or unmapped index leaves no trace, so
// software reads a setting back when it must be sure of it
always @(posedge i_sys_clk)
begin
    if (i_srst)
    begin
        qctrl_q <= `LIVS_RST_QCTRL;
        ctrl2_q <= `LIVS_RST_CTRL2;
    end
    else if (i_reg_wr)
    begin
        if (i_reg_addr == `LIVS_OFS_QCTRL)
            qctrl_q <= i_reg_wdata;
        if (i_reg_addr == `LIVS_OFS_CTRL2)
            ctrl2_q <= i_reg_wdata;
    end
end

////////////////////////////////////////////////////////////////////////////
// bus pin synchroniser and idle timer

reg                     pin_m_q;
reg                     pin_s_q;
reg                     pin_p_q;
reg  [`LIVS_IDLE_W-1:0] idle_cnt_q;
reg                     idle_hit_q;

// first stage is read only by the second stage
// the pin idles recessive high, so the stages reset to one and no
// false edge restarts the idle timer after reset
always @(posedge i_sys_clk)
begin
    if (i_srst)
    begin
        pin_m_q <= 1'b1;
        pin_s_q <= 1'b1;
        pin_p_q <= 1'b1;
    end
    else
    begin
        pin_m_q <= i_bus_pin;
        pin_s_q <= pin_m_q;
        pin_p_q <= pin_s_q;
    end
end

wire pin_edge = pin_s_q ^ pin_p_q;

// counts time since the last pin edge; a single pulse when it passes
// four seconds, then holds so a long silence raises one event only
// limitation: the count is fixed for a 10 MHz clock; another clock
// rate needs the timing macros changed as well
// the counter stops at its end value, so it never wraps and refires
always @(posedge i_sys_clk)
begin
    if (i_srst || pin_edge || !i_lin_mode)
    begin
        idle_cnt_q <= {`LIVS_IDLE_W{1'b0}};
        idle_hit_q <= 1'b0;
    end
    else if (idle_cnt_q != `LIVS_IDLE_CYC)
    begin
        idle_cnt_q <= idle_cnt_q + 1'b1;
        idle_hit_q <= (idle_cnt_q == `LIVS_IDLE_CYC - 1);
    end
    else
    begin
        idle_cnt_q <= idle_cnt_q;
        idle_hit_q <= 1'b0;
    end
end

// registered one-shot on the step into the held count
wire idle_evt = idle_hit_q;

////////////////////////////////////////////////////////////////////////////
// threshold compare on fifo levels

reg  [`LIVS_LVL_W-1:0]  rx_thr;
reg  [`LIVS_LVL_W-1:0]  tx_thr;

// threshold 00 means full; others are quarter steps of the depth
// field   rx event when level above   tx event when level below
//  00       15 (fifo full)              16
//  01        4                           4
//  10        8                           8
//  11       12                          12
// a level that stays across its threshold raises only one event
always @*
begin
    case (rx_fill_threshold)
        2'h1:    rx_thr = `LIVS_FIFO_DEPTH >> 2;
        2'h2:    rx_thr = `LIVS_FIFO_DEPTH >> 1;
        2'h3:    rx_thr = `LIVS_FIFO_DEPTH - (`LIVS_FIFO_DEPTH >> 2);
        default: rx_thr = `LIVS_FIFO_DEPTH - 5'h01;
    endcase
    case (tx_fill_threshold)
        2'h1:    tx_thr = `LIVS_FIFO_DEPTH >> 2;
        2'h2:    tx_thr = `LIVS_FIFO_DEPTH >> 1;
        2'h3:    tx_thr = `LIVS_FIFO_DEPTH - (`LIVS_FIFO_DEPTH >> 2);
        default: tx_thr = `LIVS_FIFO_DEPTH;
    endcase
end

reg                     rx_above_q;
reg                     tx_below_q;
wire                    rx_above = i_rx_level > rx_thr;
wire                    tx_below = i_tx_level < tx_thr;

// level compares become events only on the crossing edge; reset loads
// the live compare so an empty tx fifo gives no false edge after reset
always @(posedge i_sys_clk)
begin
    if (i_srst)
    begin
        rx_above_q <= rx_above;
        tx_below_q <= tx_below;
    end
    else
    begin
        rx_above_q <= rx_above;
        tx_below_q <= tx_below;
    end
end

////////////////////////////////////////////////////////////////////////////
// event gathering, bit index equals priority rank
// source index to vector code:
//    0 -> 0  wake-up request in sleep
//    1 -> 1  monitored bus activity in sleep
//    2 -> 2  identifier received ok or sent
//    3 -> 3  receive overrun
//    4 -> 4  other communication error
//    5 -> 6  receive level rose above threshold
//    6 -> 8  frame received, checksum good
//    7 -> a  transmit level fell below threshold
//    8 -> b  frame sent without error
//    9 -> c  no master response to wake-up
//   10 -> d  bus idle timeout
// i_svc_clr uses the same index

wire [`LIVS_NSRC-1:0]   evt;
assign evt[0]  = i_lin_mode && i_sleep && i_wake_det;
assign evt[1]  = i_lin_mode && i_sleep && i_bus_act && mon_en;
assign evt[2]  = i_lin_mode && (i_lin_master ? i_id_sent
                                             : i_id_ok_rx);
assign evt[3]  = i_lin_mode && i_rx_byte
                 && (i_rx_level == `LIVS_FIFO_DEPTH);
assign evt[4]  = i_lin_mode && i_comm_err;
assign evt[5]  = i_lin_mode && rx_above && !rx_above_q;
assign evt[6]  = i_lin_mode && i_rx_last && i_cksum_ok;
assign evt[7]  = i_lin_mode && tx_below && !tx_below_q;
assign evt[8]  = i_lin_mode && i_tx_last && !i_tx_err;
assign evt[9]  = i_lin_mode && i_no_resp;
assign evt[10] = i_lin_mode && idle_evt;

reg  [`LIVS_NSRC-1:0]   pend_q;

// an event taken at edge n sets its bit at n and the vector follows at
// n+1; a clear takes the same path, so software sees both one cycle
// after the pending bit moves
// sticky pending bits; a new event in the clear cycle wins
genvar gi;
generate
    for (gi = 0; gi < `LIVS_NSRC; gi = gi + 1)
    begin : g_pend
        always @(posedge i_sys_clk)
        begin
            if (i_srst)
                pend_q[gi] <= 1'b0;
            else if (evt[gi])
                pend_q[gi] <= 1'b1;
            else if (i_svc_clr[gi])
                pend_q[gi] <= 1'b0;
        end
    end
endgenerate

////////////////////////////////////////////////////////////////////////////
// priority encoder; reserved codes have no source so never appear

reg  [`LIVS_VEC_W-1:0]  vec_d;

// a reserved code would need a source wired to it; none is, so the
// encoder can only give the eleven source codes or 0fh
// lowest set index wins: scan downward so the last hit is the lowest
always @*
begin
    vec_d = `LIVS_VEC_NONE;
    if (pend_q[10]) vec_d = `LIVS_VEC_IDLE;
    if (pend_q[9])  vec_d = `LIVS_VEC_NORESP;
    if (pend_q[8])  vec_d = `LIVS_VEC_TXDONE;
    if (pend_q[7])  vec_d = `LIVS_VEC_TXPART;
    if (pend_q[6])  vec_d = `LIVS_VEC_RXDONE;
    if (pend_q[5])  vec_d = `LIVS_VEC_RXPART;
    if (pend_q[4])  vec_d = `LIVS_VEC_ERR;
    if (pend_q[3])  vec_d = `LIVS_VEC_OVR;
    if (pend_q[2])  vec_d = `LIVS_VEC_ID;
    if (pend_q[1])  vec_d = `LIVS_VEC_ACT;
    if (pend_q[0])  vec_d = `LIVS_VEC_WAKE;
end

// pending and busy read zero outside lin mode; latched bits survive a
// mode change and show again when lin mode returns
// vector and flags registered; all outputs come from flip-flops
always @(posedge i_sys_clk)
begin
    if (i_srst)
    begin
        o_vector      <= `LIVS_VEC_NONE;
        o_irq_pending <= 1'b0;
        o_busy        <= 1'b0;
    end
    else
    begin
        o_vector      <= vec_d;
        o_irq_pending <= i_lin_mode && (|pend_q);
        o_busy        <= i_lin_mode && i_sm_active;
    end
end

////////////////////////////////////////////////////////////////////////////
// read port: data valid the cycle after the read strobe

reg  [7:0]              rdata_d;

// unmapped indices read as zero; reserved bits of vector and state read as zero, the control registers read back every written bit
// reads have no side effect here; services come in on i_svc_clr
always @*
begin
    rdata_d = 8'h00;
    case (i_reg_addr)
        `LIVS_OFS_VECTOR: rdata_d = {4'h0, o_vector};
        `LIVS_OFS_STATE:
        begin
            rdata_d[`LIVS_STATE_PEND_BIT] = o_irq_pending;
            rdata_d[`LIVS_STATE_BUSY_BIT] = o_busy;
        end
        `LIVS_OFS_QCTRL:  rdata_d = qctrl_q;
        `LIVS_OFS_CTRL2:  rdata_d = ctrl2_q;
        default:          rdata_d = 8'h00;
    endcase
end

// data held only in the cycle after a read, zero otherwise
always @(posedge i_sys_clk)
begin
    if (i_srst)
        o_reg_rdata <= 8'h00;
    else if (i_reg_rd)
        o_reg_rdata <= rdata_d;
    else
        o_reg_rdata <= 8'h00;
end

endmodule
`default_nettype wire

// File: logic/livs_map.vh
/*
 * register offsets, field positions, codes and timing constants for the
 * lin interrupt vector / status block.
 * assumes: included by bare name from the design file; definitions only.
 */
`ifndef LIVS_MAP_VH
`define LIVS_MAP_VH

// register indices on the plain register port (byte wide data)
`define LIVS_ADDR_W          8
`define LIVS_OFS_VECTOR      8'h0f
`define LIVS_OFS_STATE       8'h11
`define LIVS_OFS_QCTRL       8'h13
`define LIVS_OFS_CTRL2       8'h15

// reset values
`define LIVS_RST_VECTOR      8'h0f
`define LIVS_RST_STATE       8'h00
`define LIVS_RST_QCTRL       8'h00
`define LIVS_RST_CTRL2       8'h00

// field positions
`define LIVS_STATE_PEND_BIT  1
`define LIVS_STATE_BUSY_BIT  0
`define LIVS_CTRL2_MON_BIT   3
`define LIVS_QC_TX_FILL_THRESHOLD_HI      5
`define LIVS_QC_TX_FILL_THRESHOLD_LO      4
`define LIVS_QC_RX_FILL_THRESHOLD_HI      3
`define LIVS_QC_RX_FILL_THRESHOLD_LO      2

// vector codes
`define LIVS_VEC_WAKE        4'h0
`define LIVS_VEC_ACT         4'h1
`define LIVS_VEC_ID          4'h2
`define LIVS_VEC_OVR         4'h3
`define LIVS_VEC_ERR         4'h4
`define LIVS_VEC_RXPART      4'h6
`define LIVS_VEC_RXDONE      4'h8
`define LIVS_VEC_TXPART      4'ha
`define LIVS_VEC_TXDONE      4'hb
`define LIVS_VEC_NORESP      4'hc
`define LIVS_VEC_IDLE        4'hd
`define LIVS_VEC_NONE        4'hf

// number of interrupt sources, vector width, fifo level width
`define LIVS_NSRC            11
`define LIVS_VEC_W           4
`define LIVS_LVL_W           5
`define LIVS_FIFO_DEPTH      5'h10

// idle timeout: 4 s at 10 MHz
`define LIVS_CLK_HZ          10000000
`define LIVS_IDLE_SEC        4
`define LIVS_IDLE_CYC        (`LIVS_IDLE_SEC * `LIVS_CLK_HZ)
`define LIVS_IDLE_W          26

`endif

// File: sim/livs_lin_node.sv
/*
 * stand-in for the lin bus node and frame engine: one event strobe
 * per request. assumes: one request at a time, on i_sys_clk.
 */
`timescale 1ns/10ps
`default_nettype none

module livs_lin_node
(
    // clock
    input  wire logic       i_sys_clk,
    // request from the bench
    input  wire logic       i_go,
    input  wire logic [3:0] i_kind,
    // event strobes, bit n = kind n
    output var  logic [8:0] o_ev = 9'h000
);
    // single cycle strobe, so one request is never seen twice
    always @(posedge i_sys_clk)
    begin
        o_ev <= i_go ? (9'h001 << i_kind) : 9'h000;
    end
endmodule

`default_nettype wire

// File: sim/livs_checker.sv
/*
 * port assertions for the lin vector block.
 * assumes: bound to livs_top; one clock, sync reset.
 */
`timescale 1ns/10ps
`default_nettype none

module livs_checker
(
    // ports watched
    input wire logic        i_sys_clk,
    input wire logic        i_srst,
    input wire logic [7:0]  i_reg_addr,
    input wire logic        i_reg_rd,
    input wire logic [7:0]  o_reg_rdata,
    input wire logic        i_lin_mode,
    input wire logic        i_sleep,
    input wire logic        i_sm_active,
    input wire logic        i_wake_det,
    input wire logic        i_comm_err,
    input wire logic [10:0] i_svc_clr,
    input wire logic [3:0]  o_vector,
    input wire logic        o_irq_pending,
    input wire logic        o_busy
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_srst);

    ////////////////////////////////////////////////////////////////////
    // event to vector: two cycles, lowest code wins
    rsvd_code_a:
        assert property (!(o_vector inside {4'h5, 4'h7, 4'h9, 4'he}))
        else $error("reserved vector code seen");
    none_flag_a:
        assert property ($past(i_lin_mode) |->
            ((o_vector == 4'hf) == !o_irq_pending))
        else $error("vector and pending flag disagree");
    wake_top_a:
        assert property (i_lin_mode && i_sleep && i_wake_det |-> ##2
            o_vector == 4'h0) else $error("wake not on top");
    err_raise_a:
        assert property (i_lin_mode && i_comm_err |-> ##2
            (o_irq_pending && o_vector <= 4'h4)) else $error("error lost");
    hold_pend_a:
        assert property (o_irq_pending && i_lin_mode &&
            $past(i_svc_clr) == 11'h000 |=> o_irq_pending)
        else $error("pending dropped without service");
    busy_track_a:
        assert property (i_lin_mode && i_sm_active |=> o_busy)
        else $error("busy flag missing");
    busy_follow_a:
        assert property (!$past(i_srst) |->
            o_busy == $past(i_lin_mode && i_sm_active))
        else $error("busy flag stuck");
    mode_gate_a:
        assert property (!$past(i_lin_mode) |-> !o_irq_pending)
        else $error("pending flag outside lin mode");

    ////////////////////////////////////////////////////////////////////
    // register reads: data one cycle after the strobe, else zero
    rd_idle_a:
        assert property (!$past(i_reg_rd) |-> o_reg_rdata == 8'h00)
        else $error("read data outside read slot");
    flag_read_a:
        assert property (i_reg_rd && i_reg_addr == 8'h11 |=> o_reg_rdata
            == {6'h00, $past(o_irq_pending), $past(o_busy)})
        else $error("state flags read wrong");
    vec_read_a:
        assert property (i_reg_rd && i_reg_addr == 8'h0f |=>
            o_reg_rdata == {4'h0, $past(o_vector)})
        else $error("vector read wrong");

    // main scenarios
    cover property (i_lin_mode && i_comm_err);
    cover property (o_vector == 4'h0);
    cover property (i_reg_rd && i_reg_addr == 8'h11);
endmodule

bind livs_top livs_checker u_chk (.i_sys_clk, .i_srst, .i_reg_addr,
    .i_reg_rd, .o_reg_rdata, .i_lin_mode, .i_sleep, .i_sm_active,
    .i_wake_det, .i_comm_err, .i_svc_clr, .o_vector, .o_irq_pending,
    .o_busy);

`default_nettype wire

// File: sim/tb_top.sv
/*
 * self checking bench for the lin vector block.
 * assumes: livs_lin_node makes the event strobes; 10 MHz clock.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    // bench drive and dut outputs
    logic        clk = 1'b0, srst = 1'b1, wr = 1'b0, rd = 1'b0;
    logic        mode = 1'b1, mstr = 1'b0, slp = 1'b0, sm = 1'b0;
    logic        pin = 1'b1, ck = 1'b1, terr = 1'b0, go = 1'b0;
    logic [7:0]  addr = 8'h00, wdata = 8'h00, rdata;
    logic [4:0]  rxl = 5'h00, txl = 5'h10;
    logic [10:0] svc = 11'h000;
    logic [3:0]  kind = 4'h0, vec;
    logic [8:0]  ev;
    logic        pend, busy;
    int          n_fail = 0, cmp_count = 0;
    // kind, source index and code for the plain events
    int          ks[7] = '{0, 2, 3, 5, 6, 7, 8};
    int          ix[7] = '{0, 2, 2, 4, 6, 8, 9};
    int          cc[7] = '{0, 2, 2, 4, 8, 11, 12};

    livs_lin_node node (.i_sys_clk(clk), .i_go(go), .i_kind(kind),
        .o_ev(ev));
    livs_top dut (.i_sys_clk(clk), .i_srst(srst), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_wr(wr), .i_reg_rd(rd),
        .o_reg_rdata(rdata), .i_lin_mode(mode), .i_lin_master(mstr),
        .i_sleep(slp), .i_sm_active(sm), .i_bus_pin(pin),
        .i_wake_det(ev[0]), .i_bus_act(ev[1]), .i_id_ok_rx(ev[2]),
        .i_id_sent(ev[3]), .i_rx_byte(ev[4]), .i_comm_err(ev[5]),
        .i_rx_last(ev[6]), .i_cksum_ok(ck), .i_tx_last(ev[7]),
        .i_tx_err(terr), .i_no_resp(ev[8]), .i_rx_level(rxl),
        .i_tx_level(txl), .i_svc_clr(svc), .o_vector(vec),
        .o_irq_pending(pend), .o_busy(busy));

    ////////////////////////////////////////////////////////////////////
    // clock, comparison and bus helpers
    initial forever #50 clk = ~clk;
    task chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task wreg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    // data stands only in the cycle after the strobe; it is taken at
    // the edge that ends that cycle, before the port clears it
    task rreg(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        chk(rdata, exp);
    endtask
    task pulse(input logic [3:0] k);
        @(posedge clk);
        kind <= k;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
    endtask
    task clr(input int i);
        @(posedge clk);
        svc <= 11'h001 << i;
        @(posedge clk);
        svc <= 11'h000;
    endtask
    // four edges cover strobe, latch and vector register
    task vchk(input logic [3:0] code);
        repeat (4) @(posedge clk);
        chk({4'h0, vec}, {4'h0, code});
    endtask

    ////////////////////////////////////////////////////////////////////
    // scenarios
    task t_regs;
        rreg(8'h0f, 8'h0f);
        rreg(8'h11, 8'h00);
        wreg(8'h11, 8'hff);
        rreg(8'h11, 8'h00);
        rreg(8'h20, 8'h00);
    endtask
    task t_codes;
        for (int i = 0; i < 7; i++)
        begin
            @(posedge clk);
            mstr <= (ks[i] == 3);
            slp <= (ks[i] == 0);
            pulse(4'(ks[i]));
            vchk(4'(cc[i]));
            chk({7'h00, pend}, 8'h01);
            rreg(8'h11, 8'h02);
            clr(ix[i]);
            vchk(4'hf);
        end
    endtask
    // rx full above 15 and overrun stack under wake; overrun ranks above error, rx full below
    task t_prio;
        slp <= 1'b1;
        rxl <= 5'h10;
        pulse(4'h4);
        pulse(4'h5);
        pulse(4'h0);
        vchk(4'h0);
        clr(0);
        vchk(4'h3);
        clr(3);
        vchk(4'h4);
        clr(4);
        vchk(4'h6);
        clr(5);
        vchk(4'hf);
        slp <= 1'b0;
        rxl <= 5'h00;
    endtask
    // thresholds: rx above 4, tx below 8, boundary first
    task t_thr;
        wreg(8'h13, 8'h24);
        rreg(8'h13, 8'h24);
        rxl <= 5'h04;
        vchk(4'hf);
        rxl <= 5'h05;
        vchk(4'h6);
        clr(5);
        txl <= 5'h08;
        vchk(4'hf);
        txl <= 5'h07;
        vchk(4'ha);
        clr(7);
        txl <= 5'h10;
        rxl <= 5'h00;
        vchk(4'hf);
    endtask
    // events that must be refused, then the monitored activity
    task t_gate;
        slp <= 1'b1;
        pulse(4'h1);
        vchk(4'hf);
        ck <= 1'b0;
        terr <= 1'b1;
        pulse(4'h6);
        pulse(4'h7);
        vchk(4'hf);
        mode <= 1'b0;
        pulse(4'h5);
        vchk(4'hf);
        mode <= 1'b1;
        ck <= 1'b1;
        terr <= 1'b0;
        wreg(8'h15, 8'h08);
        rreg(8'h15, 8'h08);
        pulse(4'h1);
        vchk(4'h1);
        clr(1);
        slp <= 1'b0;
        pulse(4'h1);
        vchk(4'hf);
        sm <= 1'b1;
        rreg(8'h11, 8'h01);
        chk({7'h00, busy}, 8'h01);
        sm <= 1'b0;
        pin <= 1'b0;
        vchk(4'hf);
    endtask

    task give_verdict;
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // watchdog: the scenarios need well under 2000 cycles
    initial
    begin
        repeat (5000) @(posedge clk);
        n_fail++;
        give_verdict;
    end
    initial
    begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        t_regs;
        t_codes;
        t_prio;
        t_thr;
        t_gate;
        give_verdict;
    end
endmodule

`default_nettype wire
